// >>> vic_pkg.sv
// Package of constants and types for the vectored interrupt and reset-cause block
package vic_pkg;
	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int VIC_NUM_SRC = 15;
	localparam int VIC_VEC_W = 13;
	localparam int VIC_IDX_W = 4;
	localparam int VIC_DATA_W = 8;

	// ************************************************************
	// Register offsets on the plain register port
	// ************************************************************
	localparam logic [3:0] VIC_OFS_FLAG_A = 4'h0;
	localparam logic [3:0] VIC_OFS_FLAG_B = 4'h1;
	localparam logic [3:0] VIC_OFS_FLAG_C = 4'h2;
	localparam logic [3:0] VIC_OFS_MASK_A = 4'h3;
	localparam logic [3:0] VIC_OFS_MASK_B = 4'h4;
	localparam logic [3:0] VIC_OFS_CAUSE = 4'h5;
	localparam logic [3:0] VIC_OFS_CTRL = 4'h6;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int VIC_CAUSE_TIMEOUT_BIT = 1;
	localparam int VIC_CAUSE_PWRDN_BIT = 0;
	localparam int VIC_CTRL_GIE_BIT = 0;
	localparam logic [14:0] VIC_FLAG_RST = 15'h0000;
	localparam logic [14:0] VIC_MASK_RST = 15'h0000;

	// ************************************************************
	// Source indices, priority order (0 highest)
	// ************************************************************
	localparam int VIC_SRC_WDOG = 0;
	localparam int VIC_SRC_INT0 = 1;
	localparam int VIC_SRC_TCC = 2;
	localparam int VIC_SRC_INT1 = 3;
	localparam int VIC_SRC_TBASE = 4;
	localparam int VIC_SRC_UTX = 5;
	localparam int VIC_SRC_URX = 6;
	localparam int VIC_SRC_UERR = 7;
	localparam int VIC_SRC_TC3 = 8;
	localparam int VIC_SRC_SPI = 9;
	localparam int VIC_SRC_TC4 = 10;
	localparam int VIC_SRC_INT3 = 11;
	localparam int VIC_SRC_AD = 12;
	localparam int VIC_SRC_TC2 = 13;
	localparam int VIC_SRC_INT5 = 14;

	// Vector table indexed by source, reset at address zero
	localparam logic [12:0] VIC_VEC_RESET = 13'h0000;
	localparam logic [15*13-1:0] VIC_VEC_TABLE = {
		13'h0036, 13'h0033, 13'h0030, 13'h002A, 13'h0027,
		13'h0024, 13'h0021, 13'h001B, 13'h0018, 13'h0015,
		13'h0012, 13'h000F, 13'h0009, 13'h0006, 13'h0003};

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {VIC_ST_RUN, VIC_ST_SLEEP, VIC_ST_IDLE} vic_mode_e;

	// Single-cycle instruction strobes from the core
	typedef struct packed {
		logic dog_clear_instr;
		logic sleep_instr;
		logic global_irq_on_instr;
		logic global_irq_off_instr;
		logic irq_return_instr;
	} vic_instr_s;

	// Vector request to the core
	typedef struct packed {
		logic valid;
		logic [3:0] source;
		logic [12:0] address;
	} vic_vec_s;
endpackage : vic_pkg

// >>> vic_core.sv
// Vectored interrupt controller with timeout and power-down cause bits
// Notes on behaviour
// - Power-on reset sets timeout and power-down cause bits to one.
// - Pin reset leaves both cause bits unchanged in any mode.
// - Watchdog timeout clears timeout cause bit, keeps power-down bit.
// - Watchdog-clear instruction sets both cause bits to one.
// - Sleep instruction sets timeout bit, clears power-down bit.
// - Wake-up from sleep changes neither cause bit.
// - Fifteen sources, each with fixed vector; watchdog 0003, last 0036.
// - Fixed priority from watchdog highest to external pin five lowest.
// - A source interrupts only with global enable and its mask bit set.
// - Enable instruction sets global enable; disable instruction clears it.
// - Taken interrupt makes core fetch next from that source's vector.
// - Each source request is latched in its own flag bit.
// - Flags set on event regardless of mask and global enable.
// - Return instruction restores counter from stack and sets global enable.
// - UART flags for transmit empty, receive full, error raise requests.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module vic_core #(
	parameter int NUM_SRC = vic_pkg::VIC_NUM_SRC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Reset kinds and wake events
	input wire logic power_on_reset,
	input wire logic pin_reset,
	input wire logic watchdog_timeout,
	input wire logic wake_event,
	// Core instruction strobes
	input wire vic_pkg::vic_instr_s instr,
	input wire logic irq_taken,
	// Source event pulses, one per source in priority order
	input wire logic [vic_pkg::VIC_NUM_SRC-1:0] src_event,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// To the core
	output vic_pkg::vic_vec_s vector,
	output logic irq,
	output logic timeout_cause,
	output logic pwrdn_cause,
	output logic asleep
);
	import vic_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	logic [14:0] irq_flags;
	logic [14:0] irq_masks;
	logic global_en;
	logic cause_t;
	logic cause_p;
	vic_mode_e mode;
	logic [7:0] rdata_q;

	// ************************************************************
	// Helpers
	// ************************************************************
	// Lowest set index wins, so index order is the priority order
	function automatic logic [3:0] pick_first(input logic [14:0] req);
		logic [3:0] idx;
		idx = 4'hF;
		for (int i = VIC_NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction : pick_first

	function automatic logic [12:0] vec_of(input logic [3:0] idx);
		return VIC_VEC_TABLE[idx*VIC_VEC_W +: VIC_VEC_W];
	endfunction : vec_of

	// ************************************************************
	// Register decode
	// Flag layout: a = bits 0..4, b = bits 5..9, c = bits 10..14
	// ************************************************************
	wire wr_flag_a = reg_write && reg_addr == VIC_OFS_FLAG_A;
	wire wr_flag_b = reg_write && reg_addr == VIC_OFS_FLAG_B;
	wire wr_flag_c = reg_write && reg_addr == VIC_OFS_FLAG_C;
	wire wr_mask_a = reg_write && reg_addr == VIC_OFS_MASK_A;
	wire wr_mask_b = reg_write && reg_addr == VIC_OFS_MASK_B;
	wire wr_ctrl = reg_write && reg_addr == VIC_OFS_CTRL;
	// Writing a one clears a flag; any event in the same cycle still wins
	wire [14:0] flag_clear = {wr_flag_c ? reg_wdata[4:0] : 5'h00,
		wr_flag_b ? reg_wdata[4:0] : 5'h00,
		wr_flag_a ? reg_wdata[4:0] : 5'h00};
	wire [14:0] next_flags = (irq_flags & ~flag_clear) | src_event;

	// ************************************************************
	// Selection: pending and enabled sources
	// ************************************************************
	wire [14:0] pending = irq_flags & irq_masks;
	wire any_pending = |pending;
	wire [3:0] win_idx = pick_first(pending);
	assign irq = global_en && any_pending;
	assign vector.valid = irq;
	assign vector.source = win_idx;
	assign vector.address = any_pending ? vec_of(win_idx) : VIC_VEC_RESET;
	assign timeout_cause = cause_t;
	assign pwrdn_cause = cause_p;
	assign asleep = mode != VIC_ST_RUN;
	assign reg_rdata = rdata_q;

	// ************************************************************
	// Read mux, answered one cycle after the strobe
	// ************************************************************
	logic [7:0] rd_mux;
	always_comb begin
		case (reg_addr)
			VIC_OFS_FLAG_A: rd_mux = {3'h0, irq_flags[4:0]};
			VIC_OFS_FLAG_B: rd_mux = {3'h0, irq_flags[9:5]};
			VIC_OFS_FLAG_C: rd_mux = {3'h0, irq_flags[14:10]};
			VIC_OFS_MASK_A: rd_mux = irq_masks[7:0];
			VIC_OFS_MASK_B: rd_mux = {1'b0, irq_masks[14:8]};
			VIC_OFS_CAUSE: rd_mux = {6'h00, cause_t, cause_p};
			VIC_OFS_CTRL: rd_mux = {7'h00, global_en};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= reg_read ? rd_mux : 8'h00;
		end
	end

	// ************************************************************
	// Flags and masks
	// ************************************************************
	// Flags reset only on power-on or pin reset, not on watchdog timeout; a written one also clears a flag
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_flags <= VIC_FLAG_RST;
		end else if (power_on_reset || pin_reset) begin
			irq_flags <= VIC_FLAG_RST;
		end else begin
			irq_flags <= next_flags;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_masks <= VIC_MASK_RST;
		end else if (power_on_reset || pin_reset || watchdog_timeout) begin
			irq_masks <= VIC_MASK_RST;
		end else if (wr_mask_a) begin
			irq_masks[7:0] <= reg_wdata;
		end else if (wr_mask_b) begin
			irq_masks[14:8] <= reg_wdata[6:0];
		end
	end

	// ************************************************************
	// Global enable: taking clears, on/return set, off clears, register write loads bit 0
	// ************************************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			global_en <= 1'b0;
		end else if (power_on_reset || pin_reset || watchdog_timeout) begin
			global_en <= 1'b0;
		end else if (irq_taken) begin
			global_en <= 1'b0;
		end else if (instr.global_irq_on_instr || instr.irq_return_instr) begin
			global_en <= 1'b1;
		end else if (instr.global_irq_off_instr) begin
			global_en <= 1'b0;
		end else if (wr_ctrl) begin
			global_en <= reg_wdata[VIC_CTRL_GIE_BIT];
		end
	end

	// ************************************************************
	// Cause bits; power-on has priority, pin reset and wake hold
	// ************************************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cause_t <= 1'b1;
			cause_p <= 1'b1;
		end else if (power_on_reset) begin
			cause_t <= 1'b1;
			cause_p <= 1'b1;
		end else if (pin_reset) begin
			cause_t <= cause_t;
			cause_p <= cause_p;
		end else if (watchdog_timeout) begin
			cause_t <= 1'b0;
		end else if (instr.dog_clear_instr) begin
			cause_t <= 1'b1;
			cause_p <= 1'b1;
		end else if (instr.sleep_instr) begin
			cause_t <= 1'b1;
			cause_p <= 1'b0;
		end
	end

	// ************************************************************
	// Sleep tracking; wake leaves the cause bits alone
	// ************************************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mode <= VIC_ST_RUN;
		end else begin
			case (mode)
				VIC_ST_RUN: begin
					if (instr.sleep_instr && !power_on_reset && !pin_reset) begin
						mode <= VIC_ST_SLEEP;
					end
				end
				VIC_ST_SLEEP, VIC_ST_IDLE: begin
					if (wake_event || pin_reset || power_on_reset || watchdog_timeout) begin
						mode <= VIC_ST_RUN;
					end
				end
				default: mode <= VIC_ST_RUN;
			endcase
		end
	end
endmodule : vic_core
`default_nettype wire

// >>> vic_core_sva.sv
// Assertion checker for the interrupt and reset-cause block
`timescale 1ns/100ps
`default_nettype none
module vic_core_sva #(
	parameter int NUM_SRC = 15
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Causes and strobes
	input wire logic power_on_reset,
	input wire logic pin_reset,
	input wire logic watchdog_timeout,
	input wire logic wake_event,
	input wire vic_pkg::vic_instr_s instr,
	input wire logic irq_taken,
	// Watched outputs
	input wire vic_pkg::vic_vec_s vector,
	input wire logic irq,
	input wire logic timeout_cause,
	input wire logic pwrdn_cause
);
	import vic_pkg::*;
	logic no_hard;
	logic no_instr;
	// Joint cause events resolve in fixed priority, power-on first; the other checks want their event alone
	assign no_hard = !power_on_reset && !watchdog_timeout;
	assign no_instr = !instr.dog_clear_instr && !instr.sleep_instr;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	chk_por_cause: assert property (power_on_reset |=> timeout_cause && pwrdn_cause)
		else $error("cause not set by power-on");
	chk_pin_hold: assert property (pin_reset && no_hard && no_instr |=>
		$stable({timeout_cause, pwrdn_cause})) else $error("pin reset moved cause");
	chk_wdt_cause: assert property (watchdog_timeout && !power_on_reset && !pin_reset && no_instr |=>
		!timeout_cause && $stable(pwrdn_cause)) else $error("timeout cause wrong");
	chk_clear_cause: assert property (instr.dog_clear_instr && !instr.sleep_instr && no_hard && !pin_reset
		|=> timeout_cause && pwrdn_cause) else $error("dog clear cause wrong");
	chk_sleep_cause: assert property (instr.sleep_instr && !instr.dog_clear_instr && no_hard && !pin_reset
		|=> timeout_cause && !pwrdn_cause) else $error("sleep cause wrong");
	chk_wake_hold: assert property (wake_event && no_hard && no_instr |=>
		timeout_cause == $past(timeout_cause) && pwrdn_cause == $past(pwrdn_cause))
		else $error("wake moved cause");
	chk_vec_table: assert property (vector.valid |->
		vector.address == VIC_VEC_TABLE[int'(vector.source)*13 +: 13]) else $error("bad vector");
	chk_taken_drop: assert property (irq_taken |=> !irq)
		else $error("irq stayed after taken");
endmodule : vic_core_sva
bind vic_core vic_core_sva #(.NUM_SRC(NUM_SRC)) vic_core_sva_i (.*);
`default_nettype wire

// >>> vic_core_model.sv
// Behavioural model of the core that acknowledges vectored requests
`timescale 1ns/100ps
`default_nettype none
module vic_core_model (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Request, and test controls for acknowledge and its delay
	input wire logic irq,
	input wire vic_pkg::vic_vec_s vector,
	input wire logic auto_ack,
	input wire logic [3:0] ack_delay,
	// Acknowledge and the address fetched next
	output logic irq_taken,
	output logic [12:0] taken_addr
);
	import vic_pkg::*;
	logic [3:0] wait_cnt;
	logic served;
	// One acknowledge per request; wait for the line to drop so it is not taken twice
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_taken <= 1'b0;
			served <= 1'b0;
			wait_cnt <= 4'h0;
			taken_addr <= 13'h0000;
		end else begin
			irq_taken <= 1'b0;
			if (!irq) begin
				served <= 1'b0;
				wait_cnt <= 4'h0;
			end else if (auto_ack && !served && wait_cnt == ack_delay) begin
				irq_taken <= 1'b1;
				served <= 1'b1;
				taken_addr <= vector.address;
			end else if (auto_ack && !served) begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
endmodule : vic_core_model
`default_nettype wire

// >>> vic_core_tb.sv
// Self-checking testbench for the interrupt and reset-cause block
`timescale 1ns/100ps
`default_nettype none
module vic_core_tb;
	import vic_pkg::*;
	// Stimulus: ctl holds por, pin, timeout, wake, then the instruction strobes
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [8:0] ctl = 9'h000;
	logic [14:0] src_event = 15'h0000;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic auto_ack = 1'b0;
	logic [3:0] ack_delay = 4'h0;
	logic [7:0] reg_rdata;
	vic_vec_s vector;
	logic irq, timeout_cause, pwrdn_cause, irq_taken, asleep;
	logic [12:0] taken_addr;
	int error_cnt = 0;
	int compares = 0;
	int cyc_cnt = 0;
	logic [12:0] exp_vec [15] = '{13'h0003, 13'h0006, 13'h0009, 13'h000F, 13'h0012, 13'h0015,
		13'h0018, 13'h001B, 13'h0021, 13'h0024, 13'h0027, 13'h002A, 13'h0030, 13'h0033, 13'h0036};
	always #5 clock = ~clock;
	vic_core vic_core_i (.clock(clock), .reset_n(reset_n), .power_on_reset(ctl[0]),
		.pin_reset(ctl[1]), .watchdog_timeout(ctl[2]), .wake_event(ctl[3]), .instr(ctl[8:4]),
		.irq_taken(irq_taken), .src_event(src_event), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .vector(vector),
		.irq(irq), .timeout_cause(timeout_cause), .pwrdn_cause(pwrdn_cause), .asleep(asleep));
	vic_core_model vic_core_model_i (.clock(clock), .reset_n(reset_n), .irq(irq),
		.vector(vector), .auto_ack(auto_ack), .ack_delay(ack_delay), .irq_taken(irq_taken),
		.taken_addr(taken_addr));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	// Bus and strobe drivers change signals only by NBA right after an edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		#1;
	endtask : wr
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		chk("read data", {8'h00, exp}, {8'h00, reg_rdata});
	endtask : rd_chk
	task automatic ev(input int k);
		@(posedge clock);
		ctl <= 9'h001 << k;
		@(posedge clock);
		ctl <= 9'h000;
		#1;
	endtask : ev
	task automatic fire(input logic [14:0] s);
		@(posedge clock);
		src_event <= s;
		@(posedge clock);
		src_event <= 15'h0000;
		#1;
	endtask : fire
	task automatic wait_taken;
		repeat (20) begin
			@(posedge clock);
			#1;
			if (irq_taken === 1'b1) break;
		end
		chk("acknowledge", 16'h0001, {15'h0000, irq_taken});
	endtask : wait_taken
	// Cause bits: sleep, wake, pin, timeout, clear, timeout, pin, power-on
	task automatic test_cause;
		int ks [8] = '{7, 3, 1, 2, 8, 2, 1, 0};
		logic [1:0] tp [8] = '{2'h2, 2'h2, 2'h2, 2'h0, 2'h3, 2'h1, 2'h1, 2'h3};
		logic sl [8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
		chk("cause", 16'h0003, {14'h0000, timeout_cause, pwrdn_cause});
		foreach (ks[i]) begin
			ev(ks[i]);
			chk("cause", {14'h0000, tp[i]}, {14'h0000, timeout_cause, pwrdn_cause});
			chk("asleep", {15'h0000, sl[i]}, {15'h0000, asleep});
		end
		rd_chk(VIC_OFS_CAUSE, 8'h03);
	endtask : test_cause
	// Flags latch with masks and enable off; cause is read-only, unmapped reads zero
	task automatic test_flags;
		fire(15'h7FFF);
		for (int r = 0; r < 3; r++) rd_chk(4'(r), 8'h1F);
		chk("irq", 16'h0000, {15'h0000, irq});
		for (int r = 0; r < 3; r++) wr(4'(r), 8'h1F);
		for (int r = 0; r < 3; r++) rd_chk(4'(r), 8'h00);
		rd_chk(4'hF, 8'h00);
		wr(VIC_OFS_CTRL, 8'h01);
		rd_chk(VIC_OFS_CTRL, 8'h01);
		wr(VIC_OFS_CTRL, 8'h00);
		rd_chk(VIC_OFS_CTRL, 8'h00);
		wr(VIC_OFS_CAUSE, 8'h00);
		rd_chk(VIC_OFS_CAUSE, 8'h03);
	endtask : test_flags
	// All sources pending: served one by one in fixed order, each flag cleared before return
	task automatic test_priority;
		wr(VIC_OFS_MASK_A, 8'hFF);
		wr(VIC_OFS_MASK_B, 8'h7F);
		fire(15'h7FFF);
		auto_ack <= 1'b1;
		ev(6);
		for (int i = 0; i < 15; i++) begin
			wait_taken();
			chk("vector", {3'h0, exp_vec[i]}, {3'h0, taken_addr});
			wr(4'(i / 5), 8'h01 << (i % 5));
			ev(4);
		end
	endtask : test_priority
	// Mask and global enable gate one source; slow acknowledge drops the request
	task automatic test_mask;
		auto_ack <= 1'b0;
		wr(VIC_OFS_MASK_B, 8'h00);
		fire(15'h0200);
		chk("irq", 16'h0000, {15'h0000, irq});
		wr(VIC_OFS_MASK_B, 8'h02);
		chk("irq", 16'h0001, {15'h0000, irq});
		ev(5);
		chk("irq", 16'h0000, {15'h0000, irq});
		ev(6);
		chk("irq", 16'h0001, {15'h0000, irq});
		ack_delay <= 4'h3;
		auto_ack <= 1'b1;
		wait_taken();
		chk("vector", 16'h0024, {3'h0, taken_addr});
		@(posedge clock);
		#1;
		chk("irq", 16'h0000, {15'h0000, irq});
		wr(4'h1, 8'h10);
		rd_chk(4'h1, 8'h00);
	endtask : test_mask
	task automatic stop_test;
		$display("compares %0d, errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	// The full run needs under two hundred cycles; a hang stops well past that
	always @(posedge clock) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		#1;
		test_cause();
		test_flags();
		test_priority();
		test_mask();
		stop_test();
	end
endmodule : vic_core_tb
`default_nettype wire
